//--- csp_pkg.sv
// Package: register map, field layout and constants of the serial port
package csp_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  SIG_I_IDX   = 8'hA5;
  localparam logic [7:0]  SIG_Q_IDX   = 8'hA6;
  localparam logic [7:0]  SPC_IDX     = 8'hA9;
  localparam logic [7:0]  STAT_IDX    = 8'hAA;
  localparam logic [7:0]  RXW_IDX     = 8'hAB;
  localparam int          AW          = 12;
  localparam logic [11:0] SIG_I_ADDR  = {2'h0, SIG_I_IDX, 2'h0};
  localparam logic [11:0] SIG_Q_ADDR  = {2'h0, SIG_Q_IDX, 2'h0};
  localparam logic [11:0] SPC_ADDR    = {2'h0, SPC_IDX, 2'h0};
  localparam logic [11:0] STAT_ADDR   = {2'h0, STAT_IDX, 2'h0};
  localparam logic [11:0] RXW_ADDR    = {2'h0, RXW_IDX, 2'h0};

  // Serial port control fields
  localparam int          SPC_W       = 10;
  localparam logic [9:0]  SPC_RESET   = 10'h000;
  localparam int          SPC_ROUTE   = 9;
  localparam int          SPC_FS_HI   = 8;
  localparam int          SPC_FS_LO   = 7;
  localparam int          SPC_WL_HI   = 6;
  localparam int          SPC_WL_LO   = 5;
  localparam int          SPC_MASTER  = 4;
  localparam int          SPC_DIV_HI  = 3;

  // Status fields
  localparam int          ST_RXF      = 0;
  localparam int          ST_BUSY     = 1;
  localparam int          ST_MASTER   = 2;
  localparam int          ST_PEND     = 3;

  // Frame sync styles
  localparam logic [1:0]  FS_PULSE    = 2'h0;
  localparam logic [1:0]  FS_FRAME    = 2'h1;

  // Word lengths
  localparam logic [5:0]  WL_12       = 6'h0C;
  localparam logic [5:0]  WL_16       = 6'h10;
  localparam logic [5:0]  WL_24       = 6'h18;
  localparam int          SAMP_W      = 24;
  localparam int          SIG_W       = 16;
  localparam int          RX_BITS     = 16;

  // Bit clock limit against pclk rate
  localparam int          PCLK_HZ     = 25_000_000;
  localparam int          SCLK_MAX_HZ = 80_000_000;

  typedef enum logic [1:0] {CSP_IDLE, CSP_LEAD, CSP_SHIFT} csp_state_t;

  // Word length code to bits per word
  function automatic logic [5:0] csp_wl(input logic [1:0] code);
    if (code[1])
      csp_wl = WL_24;
    else if (code[0])
      csp_wl = WL_16;
    else
      csp_wl = WL_12;
  endfunction : csp_wl

endpackage : csp_pkg

//--- csp_sync.sv
// Two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module csp_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= '0;
      q      <= '0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : csp_sync
`default_nettype wire

//--- csp_clkgen.sv
// Bit clock divider for master mode, with edge strobes
`timescale 1ns/1ps
`default_nettype none
module csp_clkgen (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  input  wire logic [3:0] div,
  output var  logic       sclk,
  output var  logic       rise,
  output var  logic       fall
);
  logic [3:0] cnt_r;

  // Half period is div+1 pclk cycles; stopped clock idles low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r <= 4'h0;
      sclk  <= 1'b0;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end
    else if (!run)
    begin
      cnt_r <= 4'h0;
      sclk  <= 1'b0;
      rise  <= 1'b0;
      fall  <= sclk;
    end
    else if (cnt_r == div)
    begin
      cnt_r <= 4'h0;
      sclk  <= ~sclk;
      rise  <= ~sclk;
      fall  <= sclk;
    end
    else
    begin
      cnt_r <= cnt_r + 4'h1;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end
  end
endmodule : csp_clkgen
`default_nettype wire

//--- csp_port.sv
// Channel serial output port: I/Q frame shifter, control input, APB regs
//
// Summary of operation
// - Master drives bit clock, slave receives it
// - Sample control input on fall, outputs on rise
// - Frame sync sampled on fall, frame starts next rise
// - Bit clock never above 80 MHz
// - Control input frames itself, independent of sync
// - I then Q, MSB first, one bit per rise
// - Data output released outside own slot
// - Slave silent until sync, then drives first bit
// - Frame end high during last bit cycle
// - Cascaded slave starts with no idle cycle
// - Word length 12, 16 or 24 bits
// - Style 00: one sync cycle before data
// - Style 01: sync high across all data bits
// - Style 1x: sync before I and before Q
// - Routing bit copies filter output to signatures
// - Sync is output as master, input as slave
// - Ports 1-3 reset as slave; port 0 strapped
`timescale 1ns/1ps
`default_nettype none
module csp_port
  import csp_pkg::*;
#(
  parameter int PORT_INDEX = 0
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [AW-1:0]     paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire logic [SAMP_W-1:0] filter_i,
  input  wire logic [SAMP_W-1:0] filter_q,
  input  wire logic              filter_valid,
  input  wire logic              port0_master_strap,
  input  wire logic              sclk_in,
  output var  logic              sclk_out,
  output var  logic              sclk_oe,
  input  wire logic              frame_sync_in,
  output var  logic              frame_sync_out,
  output var  logic              frame_sync_oe,
  output var  logic              serial_sample_output,
  output var  logic              serial_sample_oe,
  output var  logic              frame_end,
  input  wire logic              serial_control_input
);

  // Fastest generated bit clock is half of pclk
  initial
  begin
    if (PCLK_HZ / 2 > SCLK_MAX_HZ)
      $error("bit clock would exceed its limit");
    if (PORT_INDEX < 0 || PORT_INDEX > 3)
      $error("port index out of range");
  end

  logic [SPC_W-1:0]    spc_r;
  logic [SIG_W-1:0]    sig_i_r;
  logic [SIG_W-1:0]    sig_q_r;
  logic [RX_BITS-1:0]  rxw_r;
  logic                rxf_r;
  logic                master_r;
  logic [SAMP_W-1:0]   hold_i_r;
  logic [SAMP_W-1:0]   hold_q_r;
  logic                pend_r;
  csp_state_t          state_r;
  logic [47:0]         sh_r;
  logic [5:0]          cnt_r;
  logic [5:0]          wl_r;
  logic [1:0]          style_r;
  logic                fs_seen_r;
  logic                sclk_d3_r;
  logic                rx_act_r;
  logic [4:0]          rx_cnt_r;
  logic [RX_BITS-1:0]  rx_sh_r;
  logic [3:0]          s_in;
  logic                gen_sclk;
  logic                gen_rise;
  logic                gen_fall;
  logic                rise;
  logic                fall;
  logic                rx_done;
  logic                start_now;
  logic [5:0]          wl_now;
  logic [47:0]         frame_img;
  logic                wr_stb;
  logic                rd_stb;

  // Pins from outside the pclk domain
  csp_sync #(.W(4)) csp_sync_inst (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({port0_master_strap, serial_control_input,
               frame_sync_in, sclk_in}),
    .q       (s_in)
  );

  // Bit clock generator, running only as master
  csp_clkgen csp_clkgen_inst (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (master_r),
    .div     (spc_r[SPC_DIV_HI:0]),
    .sclk    (gen_sclk),
    .rise    (gen_rise),
    .fall    (gen_fall)
  );

  // Edge memory for the received bit clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sclk_d3_r <= 1'b0;
    else
      sclk_d3_r <= s_in[0];
  end

  // Edge strobes from own or far-side clock
  assign rise = master_r ? gen_rise : (s_in[0] & ~sclk_d3_r);
  assign fall = master_r ? gen_fall : (~s_in[0] & sclk_d3_r);

  // Role: port 0 follows the strap, others the register bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      master_r <= 1'b0;
    else if (PORT_INDEX == 0)
      master_r <= s_in[3];
    else
      master_r <= spc_r[SPC_MASTER];
  end

  // Pin directions follow the role
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sclk_out      <= 1'b0;
      sclk_oe       <= 1'b0;
      frame_sync_oe <= 1'b0;
    end
    else
    begin
      sclk_out      <= gen_sclk;
      sclk_oe       <= master_r;
      frame_sync_oe <= master_r;
    end
  end

  // APB decode
  assign wr_stb = psel & penable & pready & pwrite;
  assign rd_stb = psel & ~penable & ~pready;

  // No wait state: answer in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (rd_stb)
    begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (paddr == SPC_ADDR)
        prdata[SPC_W-1:0] <= spc_r;
      else if (paddr == SIG_I_ADDR)
        prdata[SIG_W-1:0] <= sig_i_r;
      else if (paddr == SIG_Q_ADDR)
        prdata[SIG_W-1:0] <= sig_q_r;
      else if (paddr == STAT_ADDR)
        prdata[ST_PEND:0] <= {pend_r, master_r,
                              state_r != CSP_IDLE, rxf_r};
      else if (paddr == RXW_ADDR)
        prdata[RX_BITS-1:0] <= rxw_r;
      else
        pslverr <= 1'b1;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      spc_r <= SPC_RESET;
    else if (wr_stb && paddr == SPC_ADDR)
      spc_r <= pwdata[SPC_W-1:0];
  end

  // Filter samples: hold for the port and optionally to signatures
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hold_i_r <= '0;
      hold_q_r <= '0;
      sig_i_r  <= '0;
      sig_q_r  <= '0;
    end
    else if (filter_valid)
    begin
      hold_i_r <= filter_i;
      hold_q_r <= filter_q;
      if (spc_r[SPC_ROUTE])
      begin
        sig_i_r <= filter_i[SAMP_W-1 -: SIG_W];
        sig_q_r <= filter_q[SAMP_W-1 -: SIG_W];
      end
    end
  end

  // Master sends one frame per new sample; a new one beats the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend_r <= 1'b0;
    else if (filter_valid)
      pend_r <= 1'b1;
    else if (rise && master_r && state_r == CSP_IDLE)
      pend_r <= 1'b0;
  end

  // Slave sync caught on falling edges, only while idle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fs_seen_r <= 1'b0;
    else if (fall && !master_r && state_r == CSP_IDLE)
      fs_seen_r <= s_in[1];
    else if (rise)
      fs_seen_r <= 1'b0;
  end

  // Word length and frame image, MSB aligned
  assign wl_now    = csp_wl(spc_r[SPC_WL_HI:SPC_WL_LO]);
  assign frame_img = (wl_now == WL_24) ? {hold_i_r, hold_q_r} :
                     (wl_now == WL_16) ?
                     {hold_i_r[23:8], hold_q_r[23:8], 16'h0000} :
                     {hold_i_r[23:12], hold_q_r[23:12], 24'h000000};
  assign start_now = master_r ? pend_r : fs_seen_r;

  // Frame shifter; all outputs change on rising bit clock edges
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r              <= CSP_IDLE;
      sh_r                 <= '0;
      cnt_r                <= 6'h00;
      wl_r                 <= WL_12;
      style_r              <= FS_PULSE;
      frame_sync_out       <= 1'b0;
      serial_sample_output <= 1'b0;
      serial_sample_oe     <= 1'b0;
      frame_end            <= 1'b0;
    end
    else if (rise)
    begin
      case (state_r)
        CSP_IDLE:
        begin
          frame_end      <= 1'b0;
          frame_sync_out <= 1'b0;
          wl_r           <= wl_now;
          // Slave ignores the style field, as only 00 is legal there
          style_r <= master_r ? spc_r[SPC_FS_HI:SPC_FS_LO]
                              : FS_PULSE;
          if (!start_now)
            serial_sample_oe <= 1'b0;
          else if (master_r && spc_r[SPC_FS_HI:SPC_FS_LO] != FS_FRAME)
          begin
            frame_sync_out   <= 1'b1;
            serial_sample_oe <= 1'b0;
            sh_r             <= frame_img;
            cnt_r            <= {wl_now[4:0], 1'b0};
            state_r          <= CSP_LEAD;
          end
          else
          begin
            frame_sync_out       <= master_r;
            serial_sample_output <= frame_img[47];
            serial_sample_oe     <= 1'b1;
            sh_r                 <= {frame_img[46:0], 1'b0};
            cnt_r                <= {wl_now[4:0], 1'b0} - 6'h01;
            state_r              <= CSP_SHIFT;
          end
        end
        CSP_LEAD:
        begin
          frame_sync_out       <= 1'b0;
          serial_sample_output <= sh_r[47];
          serial_sample_oe     <= 1'b1;
          sh_r                 <= {sh_r[46:0], 1'b0};
          cnt_r                <= cnt_r - 6'h01;
          state_r              <= CSP_SHIFT;
        end
        default:
        begin
          serial_sample_output <= sh_r[47];
          sh_r                 <= {sh_r[46:0], 1'b0};
          cnt_r                <= cnt_r - 6'h01;
          // Style 1x: pulse while the last I bit goes out
          if (style_r[1])
            frame_sync_out <= (cnt_r == wl_r + 6'h01);
          else
            frame_sync_out <= (style_r == FS_FRAME);
          if (cnt_r == 6'h01)
          begin
            frame_end <= 1'b1;
            state_r   <= CSP_IDLE;
          end
        end
      endcase
    end
  end

  // Self-framed control input: start bit then a word, on falls
  assign rx_done = fall && rx_act_r && rx_cnt_r == 5'h01;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_act_r <= 1'b0;
      rx_cnt_r <= 5'h00;
      rx_sh_r  <= '0;
      rxw_r    <= '0;
    end
    else if (fall)
    begin
      if (!rx_act_r)
      begin
        rx_act_r <= s_in[2];
        rx_cnt_r <= 5'(RX_BITS);
      end
      else
      begin
        rx_sh_r  <= {rx_sh_r[RX_BITS-2:0], s_in[2]};
        rx_cnt_r <= rx_cnt_r - 5'h01;
        if (rx_cnt_r == 5'h01)
        begin
          rx_act_r <= 1'b0;
          rxw_r    <= {rx_sh_r[RX_BITS-2:0], s_in[2]};
        end
      end
    end
  end

  // Word-received flag; a new word wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rxf_r <= 1'b0;
    else if (rx_done)
      rxf_r <= 1'b1;
    else if (wr_stb && paddr == STAT_ADDR && pwdata[ST_RXF])
      rxf_r <= 1'b0;
  end

endmodule : csp_port
`default_nettype wire

//--- csp_port_properties.sv
// Checker for the serial output port, bound to every csp_port
`timescale 1ns/1ps
`default_nettype none
module csp_port_checker
  import csp_pkg::*;
#(
  parameter int PORT_INDEX = 0
) (
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0]   pwdata,
  input wire logic          pready,
  input wire logic          frame_sync_in,
  input wire logic          sclk_out,
  input wire logic          sclk_oe,
  input wire logic          frame_sync_out,
  input wire logic          frame_sync_oe,
  input wire logic          serial_sample_output,
  input wire logic          serial_sample_oe,
  input wire logic          frame_end
);
  logic       mst_ok_r;
  logic [4:0] fs_age_r;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Sticky: software asked for master; sticky so it never fires falsely
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mst_ok_r <= 1'h0;
    else if (psel && penable && pready && pwrite && paddr == SPC_ADDR)
      mst_ok_r <= mst_ok_r | pwdata[SPC_MASTER];
  end

  // Cycles since the sync pin was last high, saturating
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fs_age_r <= 5'h1F;
    else if (frame_sync_in)
      fs_age_r <= 5'h00;
    else if (fs_age_r != 5'h1F)
      fs_age_r <= fs_age_r + 5'h01;
  end

  // Pin roles and slot timing
  property p_role_pair; sclk_oe == frame_sync_oe; endproperty
  a_role_pair: assert property (p_role_pair)
    else $error("clock and sync drivers disagree");
  property p_reset_slave; PORT_INDEX != 0 && !mst_ok_r |-> !sclk_oe; endproperty
  a_reset_slave: assert property (p_reset_slave)
    else $error("master without register request");
  property p_end_in_slot; frame_end |-> serial_sample_oe; endproperty
  a_end_in_slot: assert property (p_end_in_slot)
    else $error("frame end outside slot");
  property p_end_width; $rose(frame_end) |=> frame_end; endproperty
  a_end_width: assert property (p_end_width)
    else $error("frame end shorter than a bit");
  property p_data_rise; sclk_oe && $changed(serial_sample_output) |-> sclk_out;
  endproperty
  a_data_rise: assert property (p_data_rise)
    else $error("data changed off a rise");
  property p_end_rise; sclk_oe && $changed(frame_end) |-> sclk_out; endproperty
  a_end_rise: assert property (p_end_rise)
    else $error("frame end changed off a rise");
  property p_sync_rise; sclk_oe && $changed(frame_sync_out) |-> sclk_out;
  endproperty
  a_sync_rise: assert property (p_sync_rise)
    else $error("sync changed off a rise");
  property p_slot_rise; sclk_oe && $changed(serial_sample_oe) |-> sclk_out;
  endproperty
  a_slot_rise: assert property (p_slot_rise)
    else $error("slot enable changed off a rise");
  property p_slave_start;
    !sclk_oe && $rose(serial_sample_oe) |-> fs_age_r < 5'h10;
  endproperty
  a_slave_start: assert property (p_slave_start)
    else $error("slave slot without sync");

  c_master_end: cover property (sclk_oe && $rose(frame_end));
  c_slave_end: cover property (!sclk_oe && $rose(frame_end));
  c_sync_out: cover property ($rose(frame_sync_out));
endmodule : csp_port_checker

bind csp_port csp_port_checker #(.PORT_INDEX(PORT_INDEX))
  csp_port_checker_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .frame_sync_in, .sclk_out, .sclk_oe, .frame_sync_out, .frame_sync_oe,
  .serial_sample_output, .serial_sample_oe, .frame_end
);
`default_nettype wire

//--- csp_dsp_model.sv
// Far-side processor model: bit clock, frame sync and control bits
`timescale 1ns/1ps
`default_nettype none
module csp_dsp_model (
  output var logic sclk,
  output var logic fsync,
  output var logic ctl
);
  // Clock rests low between bursts, as a real processor port does
  initial
  begin
    sclk = 1'h0;
    fsync = 1'h0;
    ctl = 1'h0;
  end

  // 320 ns bit clock; sync and control change mid-high, held over the fall
  task automatic burst(input int n, input int fa, input int fb,
                       input logic [16:0] word);
    // Start off the pclk edge so no input moves as it is sampled
    #10;
    for (int j = 0; j < n; j++)
    begin
      sclk = 1'h1;
      #80;
      fsync = (j == fa) || (j == fb);
      ctl = (j < 17) ? word[16-j] : 1'h0;
      #80;
      sclk = 1'h0;
      #160;
    end
    fsync = 1'h0;
  endtask : burst
endmodule : csp_dsp_model
`default_nettype wire

//--- channel_serial_output_port_tb.sv
// Testbench for the channel serial output port
`timescale 1ns/1ps
`default_nettype none
module channel_serial_output_port_tb
  import csp_pkg::*;
;
  logic              pclk = 1'h0;
  logic              presetn = 1'h0;
  logic              psel = 1'h0;
  logic              penable = 1'h0;
  logic              pwrite = 1'h0;
  logic [AW-1:0]     paddr = 12'h000;
  logic [31:0]       pwdata = 32'h0;
  logic [SAMP_W-1:0] filter_i = 24'h0;
  logic [SAMP_W-1:0] filter_q = 24'h0;
  logic              filter_valid = 1'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              sclk_out;
  logic              sclk_oe;
  logic              frame_sync_out;
  logic              frame_sync_oe;
  logic              serial_sample_output;
  logic              serial_sample_oe;
  logic              frame_end;
  wire logic         dsp_sclk;
  wire logic         dsp_fs;
  wire logic         dsp_ctl;
  int                n_mismatch = 0;
  int                checked = 0;
  logic [3:0]        rec[$];
  logic [3:0]        snap = 4'h0;
  logic              sclk_q = 1'h0;

  // Shared wires: whoever drives wins
  wire logic sclk_w = sclk_oe ? sclk_out : dsp_sclk;
  wire logic fs_w = frame_sync_oe ? frame_sync_out : dsp_fs;

  csp_port #(.PORT_INDEX(1)) csp_port_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .filter_i, .filter_q, .filter_valid,
    .port0_master_strap(1'h1), .sclk_in(sclk_w), .sclk_out, .sclk_oe,
    .frame_sync_in(fs_w), .frame_sync_out, .frame_sync_oe,
    .serial_sample_output, .serial_sample_oe, .frame_end,
    .serial_control_input(dsp_ctl)
  );
  csp_dsp_model csp_dsp_model_inst (
    .sclk(dsp_sclk), .fsync(dsp_fs), .ctl(dsp_ctl)
  );

  always #20 pclk = ~pclk;

  // Per bit-clock rise, keep what the lines showed just before it
  always @(negedge pclk)
  begin
    if (sclk_w && !sclk_q)
      rec.push_back(snap);
    snap = {fs_w, serial_sample_oe, serial_sample_output, frame_end};
    sclk_q = sclk_w;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic cmp(input string w, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", w, e, g);
      n_mismatch++;
    end
  endtask : cmp

  // Bus master: hold everything until pready is seen high
  task automatic apb(input logic w, input logic [AW-1:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'h1, a, d, rd, er);
  endtask : wr

  task automatic rdchk(input logic [AW-1:0] a, input logic [31:0] e,
                       input logic ee);
    logic [31:0] rd;
    logic        er;
    apb(1'h0, a, 32'h0, rd, er);
    cmp("read data", e, rd);
    cmp("slave error", {31'h0, ee}, {31'h0, er});
  endtask : rdchk

  task automatic load(input logic [23:0] i, input logic [23:0] q);
    @(posedge pclk);
    filter_i <= i;
    filter_q <= q;
    filter_valid <= 1'h1;
    @(posedge pclk);
    filter_valid <= 1'h0;
  endtask : load

  // Judge nf frames from the first slot cycle; st < 0 skips the sync
  task automatic chk(input logic [23:0] fi, input logic [23:0] fq,
                     input int wl, input int st, input int nf);
    int   r;
    int   i;
    logic b;
    r = 0;
    while (r < rec.size() && rec[r][2] !== 1'h1)
      r++;
    cmp("slot before sync", 32'h0, 32'(rec[r-1][2]));
    for (int k = 0; k < 2*wl*nf; k++)
    begin
      i = k % (2*wl);
      b = (i < wl) ? fi[23-i] : fq[23-i+wl];
      cmp("slot bit", {29'h1, b, i == 2*wl-1},
          32'(rec[r+k][2:0]));
    end
    cmp("slot after", 32'h0, 32'(rec[r+2*wl*nf][2]));
    for (int k = -1; st >= 0 && k <= 2*wl; k++)
      cmp("frame sync", (st == 1) ? (k >= 0 && k < 2*wl) :
          (k == -1 || (st > 1 && k == wl-1)),
          rec[r+k][3]);
  endtask : chk

  function automatic int wlb(input int c);
    return c[1] ? 24 : (c[0] ? 16 : 12);
  endfunction : wlb

  task automatic t_regs();
    cmp("clock driven", 32'h0, {31'h0, sclk_oe});
    cmp("sync driven", 32'h0, {31'h0, frame_sync_oe});
    rdchk(SPC_ADDR, 32'h0, 1'h0);
    wr(SPC_ADDR, 32'hFFFF_FC6F);
    rdchk(SPC_ADDR, 32'h6F, 1'h0);
    rdchk(12'h000, 32'h0, 1'h1);
    wr(SPC_ADDR, 32'h200);
    load(24'h3C5AF1, 24'hC3A50E);
    rdchk(SIG_I_ADDR, 32'h3C5A, 1'h0);
    rdchk(SIG_Q_ADDR, 32'hC3A5, 1'h0);
  endtask : t_regs

  // Slave frames clocked by the far side, control word sent alongside
  task automatic t_slave(input int c, input int fb, input int nf);
    wr(SPC_ADDR, 32'(c) << 5);
    load(24'hA5C3B1 ^ 24'(c), 24'h5A3C4E);
    rec.delete();
    csp_dsp_model_inst.burst(2*wlb(c)*nf + 3, 0, fb, 17'h19A6C);
    repeat (10) @(posedge pclk);
    chk(24'hA5C3B1 ^ 24'(c), 24'h5A3C4E, wlb(c), -1, nf);
  endtask : t_slave

  // Master frame: divider 1, style and word code both s
  task automatic t_master(input int s);
    int   n;
    logic hi;
    wr(SPC_ADDR, (32'(s) << 7) | (32'(s) << 5) | 32'h11);
    // A sample still pending from slave runs goes out first; let it drain
    repeat (150) @(posedge pclk);
    cmp("clock driven", 32'h1, {31'h0, sclk_oe});
    cmp("sync driven", 32'h1, {31'h0, frame_sync_oe});
    rec.delete();
    load(24'h96E1D7, 24'h1B7C28);
    n = 0;
    hi = 1'h0;
    while (n < 1000 && !(hi && serial_sample_oe === 1'h0))
    begin
      @(posedge pclk);
      hi = hi | (serial_sample_oe === 1'h1);
      n++;
    end
    cmp("slot closed", 32'h1,
        {31'h0, hi && serial_sample_oe === 1'h0});
    repeat (10) @(posedge pclk);
    chk(24'h96E1D7, 24'h1B7C28, wlb(s), s, 1);
  endtask : t_master

  // Control word from the slave bursts, and its flag in the status word
  task automatic t_ctl();
    rdchk(RXW_ADDR, 32'h9A6C, 1'h0);
    rdchk(STAT_ADDR, 32'h9, 1'h0);
    wr(STAT_ADDR, 32'h1);
    rdchk(STAT_ADDR, 32'h8, 1'h0);
  endtask : t_ctl

  // Main sequence
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_regs();
    for (int c = 0; c < 4; c++)
      t_slave(c, 10, 1);
    t_slave(0, 24, 2);
    t_ctl();
    for (int s = 0; s < 4; s++)
      t_master(s);
    tally_and_finish();
  end

  // Watchdog: all tests finish well inside 20000 cycles
  initial
  begin
    #800000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule : channel_serial_output_port_tb
`default_nettype wire
